/* hw/pbm_pkg.sv */
package pbm_pkg;
  // pin count and upper address bit range
  localparam int          PBM_NPINS      = 5;
  localparam int          PBM_ADDR_LSB   = 16;
  // register byte addresses on the avalon slave
  localparam logic [3:0]  PBM_OFS_DATA   = 4'h0;
  localparam logic [3:0]  PBM_OFS_DIR    = 4'h4;
  localparam logic [3:0]  PBM_OFS_PER    = 4'h8;
  localparam logic [3:0]  PBM_OFS_PUR    = 4'hc;
  localparam logic [3:0]  PBM_OFS_BCR    = 4'h0;
  localparam logic [3:0]  PBM_OFS_PIN    = 4'h4;
  // field positions in bus_control_reg
  localparam int          PBM_BCR_DRV    = 0;
  localparam int          PBM_BCR_MODE   = 1;
  // reset values
  localparam logic [4:0]  PBM_RST_PUR    = 5'h1f;
  localparam logic [4:0]  PBM_RST_ZERO   = 5'h00;
  localparam logic [1:0]  PBM_RST_BCR    = 2'h0;
  localparam logic [31:0] PBM_UNMAPPED   = 32'h0000_0000;
  // reset-time address selection of pins 0 to 3, pin 4 stays gpio
  localparam logic [4:0]  PBM_ADDR_SEL   = 5'h0f;
endpackage : pbm_pkg

/* hw/pbm_pin_cell.sv */
`timescale 1ns/1ps
`default_nettype none
// one port b pin: chooses gpio or address drive, pull-up and enable
module pbm_pin_cell
  import pbm_pkg::*;
(
  input  wire logic in_reset,
  input  wire logic per_bit,
  input  wire logic dir_bit,
  input  wire logic data_bit,
  input  wire logic pur_bit,
  input  wire logic addr_bit,
  input  wire logic bus_active,
  input  wire logic drive_select,
  output logic      pin_o,
  output logic      pin_oe,
  output logic      pin_pu
);
  // address drive may be released when the bus is idle
  wire addr_oe = bus_active | drive_select;
  // gpio drives only when set as output
  wire gpio_oe = dir_bit;
  // final pin selection, reset forces input with pull-up
  assign pin_o  = per_bit ? addr_bit : data_bit;
  assign pin_oe = in_reset ? 1'b0 : (per_bit ? addr_oe : gpio_oe);
  assign pin_pu = in_reset ? 1'b1 : (pur_bit & ~pin_oe);
endmodule : pbm_pin_cell
`default_nettype wire

/* hw/pbm_port_b_mux.sv */
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pbm_port_b_mux
  import pbm_pkg::*;
#(
  parameter int NPINS = PBM_NPINS
)
(
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // avalon-mm slave
  input  wire logic [3:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic             avs_chipselect_ctl,
  // reset-time straps
  input  wire logic             external_boot_select,
  input  wire logic             ext_interface_mode,
  input  wire logic             flash_secure,
  // external memory interface side
  input  wire logic [NPINS-1:0] emi_addr_hi,
  input  wire logic             emi_bus_active,
  output logic                  bus_drive_select,
  // pins
  input  wire logic [NPINS-1:0] port_b_i,
  output logic [NPINS-1:0]      port_b_o,
  output logic [NPINS-1:0]      port_b_oe,
  output logic [NPINS-1:0]      port_b_pu
);
  // reset release through two flops
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n_i  = rst_s2_r;
  wire in_reset = ~rst_n_i;

  // registers
  logic [NPINS-1:0] data_r;
  logic [NPINS-1:0] dir_r;
  logic [NPINS-1:0] per_r;
  logic [NPINS-1:0] pur_r;
  logic [1:0]       bcr_r;
  logic             strap_done_r;
  logic             ack_r;
  logic [31:0]      rdata_r;

  // address role at boot unless secured, or when interface mode asks it
  wire boot_addr = (external_boot_select & ~flash_secure) | ext_interface_mode;
  wire [NPINS-1:0] strap_per = boot_addr ? PBM_ADDR_SEL[NPINS-1:0]
                                         : PBM_RST_ZERO[NPINS-1:0];

  // address decode, chipselect_ctl picks the control page
  wire acc      = avs_read | avs_write;
  wire wr_go    = avs_write & ack_r;
  wire sel_data = ~avs_chipselect_ctl & (avs_address == PBM_OFS_DATA);
  wire sel_dir  = ~avs_chipselect_ctl & (avs_address == PBM_OFS_DIR);
  wire sel_per  = ~avs_chipselect_ctl & (avs_address == PBM_OFS_PER);
  wire sel_pur  = ~avs_chipselect_ctl & (avs_address == PBM_OFS_PUR);
  wire sel_bcr  =  avs_chipselect_ctl & (avs_address == PBM_OFS_BCR);
  wire sel_pin  =  avs_chipselect_ctl & (avs_address == PBM_OFS_PIN);
  wire [NPINS-1:0] wd = avs_writedata[NPINS-1:0];

  // read multiplexer
  wire [31:0] rd_mux =
      sel_data ? {{(32-NPINS){1'b0}}, data_r} :
      sel_dir  ? {{(32-NPINS){1'b0}}, dir_r}  :
      sel_per  ? {{(32-NPINS){1'b0}}, per_r}  :
      sel_pur  ? {{(32-NPINS){1'b0}}, pur_r}  :
      sel_bcr  ? {30'h0000_0000, bcr_r}       :
      sel_pin  ? {{(32-NPINS){1'b0}}, port_b_i} : PBM_UNMAPPED;

  // one wait cycle, then the access completes
  always_ff @(posedge sys_clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ack_r <= 1'b0;
    else
      ack_r <= acc & ~ack_r;
  end
  assign avs_waitrequest = acc & ~ack_r;

  always_ff @(posedge sys_clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_r <= PBM_UNMAPPED;
    else if (avs_read & ~ack_r)
      rdata_r <= rd_mux;
  end
  assign avs_readdata = rdata_r;

  // gpio data and direction
  always_ff @(posedge sys_clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data_r <= PBM_RST_ZERO[NPINS-1:0];
      dir_r  <= PBM_RST_ZERO[NPINS-1:0];
    end
    else
    begin
      if (wr_go & sel_data)
        data_r <= wd;
      if (wr_go & sel_dir)
        dir_r <= wd;
    end
  end

  // role select: straps once after release, then software
  always_ff @(posedge sys_clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      per_r        <= PBM_RST_ZERO[NPINS-1:0];
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      per_r        <= strap_per;
      strap_done_r <= 1'b1;
    end
    else if (wr_go & sel_per)
      per_r <= wd;
  end

  // pull-up and bus control
  always_ff @(posedge sys_clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pur_r <= PBM_RST_PUR[NPINS-1:0];
      bcr_r <= PBM_RST_BCR;
    end
    else
    begin
      if (wr_go & sel_pur)
        pur_r <= wd;
      if (wr_go & sel_bcr)
        bcr_r <= avs_writedata[1:0];
    end
  end
  assign bus_drive_select = bcr_r[PBM_BCR_DRV];

  // one cell per pin
  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_pin
      pbm_pin_cell u_cell (
        .in_reset     (in_reset),
        .per_bit      (per_r[g]),
        .dir_bit      (dir_r[g]),
        .data_bit     (data_r[g]),
        .pur_bit      (pur_r[g]),
        .addr_bit     (emi_addr_hi[g]),
        .bus_active   (emi_bus_active),
        .drive_select (bcr_r[PBM_BCR_DRV]),
        .pin_o        (port_b_o[g]),
        .pin_oe       (port_b_oe[g]),
        .pin_pu       (port_b_pu[g])
      );
    end
  endgenerate
endmodule : pbm_port_b_mux
`default_nettype wire

/* verification/pbm_port_b_mux_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the port b mux
module pbm_mux_asserts
  import pbm_pkg::*;
#(parameter int NPINS = PBM_NPINS)
(
  input wire logic             sys_clk,
  input wire logic             rstn,
  input wire logic [3:0]       avs_address,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_writedata,
  input wire logic [31:0]      avs_readdata,
  input wire logic             avs_waitrequest,
  input wire logic             avs_chipselect_ctl,
  input wire logic [NPINS-1:0] emi_addr_hi,
  input wire logic             emi_bus_active,
  input wire logic             bus_drive_select,
  input wire logic [NPINS-1:0] port_b_o,
  input wire logic [NPINS-1:0] port_b_oe,
  input wire logic [NPINS-1:0] port_b_pu
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // completed accesses
  wire wr_done = avs_write & ~avs_waitrequest;
  wire rd_done = avs_read & ~avs_waitrequest;
  // previous-cycle copies kept in clocked code
  logic [NPINS-1:0] oe_prev_r;
  logic             wr_prev_r;
  always_ff @(posedge sys_clk)
  begin
    oe_prev_r <= port_b_oe;
    wr_prev_r <= wr_done;
  end
  wire oe_moved = (port_b_oe != oe_prev_r) && !wr_prev_r;
  sequence s_start;
    (avs_read | avs_write) & avs_waitrequest;
  endsequence
  sequence s_bcr_wr;
    wr_done & avs_chipselect_ctl & (avs_address == PBM_OFS_BCR);
  endsequence
  a_one_wait: assert property (s_start |=> !avs_waitrequest)
    else $error("access not answered after one wait");
  a_reset_pins: assert property (disable iff (1'b0) !rstn |->
    port_b_oe == '0 && port_b_pu == '1) else $error("pins active in reset");
  a_drive_write: assert property (s_bcr_wr |=>
    bus_drive_select == $past(avs_writedata[PBM_BCR_DRV]))
    else $error("drive select not written");
  a_drive_hold: assert property (!$stable(bus_drive_select) |->
    $past(wr_done & avs_chipselect_ctl)) else $error("drive select moved");
  a_oe_cause: assert property (oe_moved |->
    emi_bus_active != $past(emi_bus_active) && !bus_drive_select)
    else $error("enable changed without cause");
  a_addr_follow: assert property (oe_moved |->
    ((port_b_o ^ emi_addr_hi) & (port_b_oe ^ $past(port_b_oe))) == '0)
    else $error("address pin not following address");
  a_pu_off: assert property ((port_b_pu & port_b_oe) == '0)
    else $error("pull-up on while driving");
  a_upper_zero: assert property (rd_done |->
    avs_readdata[31:NPINS] == '0) else $error("upper read bits set");
endmodule : pbm_mux_asserts
bind pbm_port_b_mux pbm_mux_asserts #(.NPINS(NPINS)) i_chk (.*);
`default_nettype wire

/* verification/pbm_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// board pins: driven, pulled up, or floating with a changing level
module pbm_pin_model
  import pbm_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic [PBM_NPINS-1:0] pin_o,
  input  wire logic [PBM_NPINS-1:0] pin_oe,
  input  wire logic [PBM_NPINS-1:0] pin_pu,
  output logic [PBM_NPINS-1:0]      pin_lvl
);
  logic [PBM_NPINS-1:0] float_r = '0;
  // a released line without pull-up never keeps its last value; with pull-up it stays high
  always @(posedge sys_clk)
    float_r <= ~float_r;
  assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & (pin_pu | float_r));
endmodule : pbm_pin_model
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pbm_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        cs = 1'b0;
  logic        act = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [4:0]  ahi = 5'h0;
  logic [4:0]  rv, po, poe, ppu, plvl;
  logic [31:0] rdat;
  logic        wreq, dsel;
  logic [31:0] exp_q[$];
  int          errors = 0, cmp_count = 0, seed = 71;
  always #50 sys_clk = ~sys_clk;
  pbm_port_b_mux i_dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .avs_chipselect_ctl(cs),
    .external_boot_select(1'b1), .ext_interface_mode(1'b0),
    .flash_secure(1'b0), .emi_addr_hi(ahi), .emi_bus_active(act),
    .bus_drive_select(dsel), .port_b_i(plvl), .port_b_o(po),
    .port_b_oe(poe), .port_b_pu(ppu));
  pbm_pin_model i_pins (.sys_clk(sys_clk), .pin_o(po), .pin_oe(poe),
    .pin_pu(ppu), .pin_lvl(plvl));
  task automatic check(string nm, logic [31:0] seen, logic [31:0] expv);
    cmp_count++;
    if (seen !== expv)
    begin
      errors++;
      $display("[FAIL] %s exp %h seen %h", nm, expv, seen);
    end
  endtask : check
  // one avalon access; a read notes its expected data for the monitor
  task automatic acc(logic w, logic c, logic [3:0] a, logic [31:0] d);
    @(posedge sys_clk);
    {wr, rd, cs, adr, wd} <= {w, ~w, c, a, d};
    if (!w) exp_q.push_back(d);
    // wait for the answer; only the watchdog ends a hang
    do @(posedge sys_clk); while (wreq !== 1'b0);
    {wr, rd} <= 2'b00;
  endtask : acc
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // compares each completed read with the oldest noted value
  always @(posedge sys_clk)
    if (rd && wreq === 1'b0)
      check("readdata", rdat, exp_q.pop_front());
  initial
  begin
    #200us;
    errors++;
    end_sim();
  end
  initial
  begin
    @(negedge sys_clk);
    check("oe", poe, 5'h00);
    check("pu", ppu, 5'h1f);
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    acc(0, 0, PBM_OFS_PER, 32'h0f);
    ahi <= 5'($random(seed));
    act <= 1'b1;
    @(negedge sys_clk);
    check("addr oe", poe, 5'h0f);
    check("addr", po[3:0], ahi[3:0]);
    @(posedge sys_clk) act <= 1'b0;
    @(negedge sys_clk);
    check("idle oe", poe, 5'h00);
    acc(1, 1, PBM_OFS_BCR, 32'h1);
    acc(0, 1, PBM_OFS_BCR, 32'h1);
    check("held oe", poe, 5'h0f);
    acc(1, 0, PBM_OFS_PER, 32'h1f);
    @(negedge sys_clk);
    check("addr4", po, ahi);
    $display("test address done");
    rv = 5'($random(seed));
    acc(1, 0, PBM_OFS_PER, 32'h0);
    acc(1, 0, PBM_OFS_DIR, 32'h1f);
    acc(1, 0, PBM_OFS_DATA, 32'(rv));
    @(negedge sys_clk);
    check("gpio out", {poe, po}, {5'h1f, rv});
    acc(1, 0, PBM_OFS_DIR, 32'h0);
    acc(0, 1, PBM_OFS_PIN, 32'h1f);
    acc(1, 0, PBM_OFS_PUR, 32'h0);
    @(negedge sys_clk);
    check("pu off", ppu, 5'h00);
    acc(1, 1, 4'h8, 32'hff);
    acc(0, 1, 4'h8, 32'h0);
    $display("test gpio done");
    repeat (2) @(posedge sys_clk);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
